// File: verilog/pli_pop_pkg.sv
// Purpose: Shared constants and types for the preload-hint and unstack block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Struct field order fixes the bit positions of control and status words
`default_nettype none
package pli_pop_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [7:0] INSTR_OFS  = 8'h00;
    localparam logic [7:0] CTRL_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] HINT_OFS   = 8'h0C;
    localparam logic [7:0] PC_OFS     = 8'h10;
    localparam logic [7:0] BRANCH_OFS = 8'h14;
    localparam logic [1:0] REGS_BANK  = 2'h1;   // 0x40..0x7C, r0..r15

    // Control word bit positions (match ctrl_type)
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_IS16_BIT  = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Register numbers and fixed values
    localparam logic [3:0]  SP_IDX     = 4'hD;
    localparam logic [3:0]  PC_IDX     = 4'hF;
    localparam logic [3:0]  ALL_ONES4  = 4'hF;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    localparam logic [31:0] ALIGN4     = 32'hFFFF_FFFC;
    localparam logic [31:0] CLR_BIT0   = 32'hFFFF_FFFE;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_HINT = 2'h1,
        OP_POP  = 2'h2
    } op_type;

    typedef struct packed {
        op_type      op;
        logic [3:0]  base;
        logic [3:0]  index;
        logic        use_index;
        logic [31:0] imm;
        logic        add;
        logic [1:0]  shift;
        logic [15:0] list;
        logic        unaligned_ok;
        logic        unpredictable;
    } decode_type;

    typedef struct packed {
        logic is16;
        logic carry;
        logic last_in_group;
        logic in_group;
        logic cond_pass;
        logic start;
    } ctrl_type;

    typedef struct packed {
        logic unaligned_ok;
        logic unpredictable;
        logic mem_fault;
        logic usage_error;
        logic branched;
        logic hinted;
        logic done;
        logic busy;
    } status_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        unaligned_ok;
    } mem_req_type;

    function automatic logic [4:0] count_bits(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h0;
        for (int i = 0; i < 16; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction

endpackage
`default_nettype wire

// File: verilog/pli_pop_decoder.sv
// Purpose: Field decode of the preload-hint and unstack instruction groups
// Assumes: hw1 is the first halfword; hw2 is ignored for 16-bit forms
// Notes:   Purely combinational
`default_nettype none
module pli_pop_decoder (
    input  wire logic                    [15:0] hw1,           // First halfword
    input  wire logic                    [15:0] hw2,           // Second halfword
    input  wire logic                           is16,          // 16-bit encoding
    input  wire logic                           in_group,      // Inside conditional group
    input  wire logic                           last_in_group, // Last of that group
    output pli_pop_pkg::decode_type             dec            // Decoded fields
);
    import pli_pop_pkg::*;

    logic pc_bad;

    always_comb begin
        dec = '0;
        dec.op = OP_NONE;
        if (is16) begin
            if (hw1[15:9] == 7'h5E) begin
                dec.op   = OP_POP;
                dec.list = {hw1[8], 7'h00, hw1[7:0]};
                dec.unpredictable = (count_bits(dec.list) == 5'h0);
            end
        end else if ((hw1 & 16'hFF7F) == 16'hF91F && hw2[15:12] == 4'hF) begin
            dec.op   = OP_HINT;
            dec.base = PC_IDX;
            dec.imm  = {20'h00000, hw2[11:0]};
            dec.add  = hw1[7];
        end else if (hw1[15:4] == 12'hF99 && hw2[15:12] == 4'hF) begin
            dec.op   = OP_HINT;
            dec.base = hw1[3:0];
            dec.imm  = {20'h00000, hw2[11:0]};
            dec.add  = 1'b1;
        end else if (hw1[15:4] == 12'hF91 && hw2[15:8] == 8'hFC) begin
            dec.op   = OP_HINT;
            dec.base = hw1[3:0];
            dec.imm  = {24'h000000, hw2[7:0]};
            dec.add  = 1'b0;
        end else if (hw1[15:4] == 12'hF91 && hw2[15:6] == 10'h3C0) begin
            dec.op        = OP_HINT;
            dec.base      = hw1[3:0];
            dec.index     = hw2[3:0];
            dec.use_index = 1'b1;
            dec.add       = 1'b1;
            dec.shift     = hw2[5:4];
            dec.unpredictable = (hw2[3:0] == SP_IDX) || (hw2[3:0] == PC_IDX);
        end else if (hw1 == 16'hE8BD && !hw2[13]) begin
            dec.op   = OP_POP;
            dec.list = {hw2[15], hw2[14], 1'b0, hw2[12:0]};
            dec.unpredictable = (count_bits(dec.list) < 5'h2)
                || (hw2[15] && hw2[14]);
        end else if (hw1 == 16'hF85D && hw2[11:0] == 12'hB04) begin
            dec.op           = OP_POP;
            dec.list         = 16'h0001 << hw2[15:12];
            dec.unaligned_ok = 1'b1;
            dec.unpredictable = (hw2[15:12] == SP_IDX);
        end
        pc_bad = dec.list[PC_IDX] && in_group && !last_in_group;
        if (dec.op == OP_POP && pc_bad) begin
            dec.unpredictable = 1'b1;
        end
    end

endmodule
`default_nettype wire

// File: verilog/pli_pop_unit.sv
// Purpose: Execute preload hints and unstack for one instruction held in registers
// Assumes: Memory port on pclk; mem_ack marks read data, one word per request
// Notes:   Software loads the register image, the instruction and then starts it
`default_nettype none

module pli_pop_unit (
    input  wire logic                     pclk,          // Core clock
    input  wire logic                     presetn,       // Async reset, active low
    input  wire logic               [7:0] paddr,         // APB address
    input  wire logic                     psel,          // APB select
    input  wire logic                     penable,       // APB enable
    input  wire logic                     pwrite,        // APB write
    input  wire logic              [31:0] pwdata,        // APB write data
    output logic                   [31:0] prdata,        // APB read data
    output logic                          pready,        // APB ready
    output logic                          pslverr,       // APB error
    output pli_pop_pkg::mem_req_type      mem_req,       // Load request, held to ack
    input  wire logic                     mem_ack,       // Load answer strobe
    input  wire logic              [31:0] mem_rdata,     // Load data
    input  wire logic                     mem_err,       // Load failed
    output logic                          hint_valid,    // Preload hint pulse
    output logic                   [31:0] hint_addr,     // Preload hint address
    output logic                          branch_valid,  // Branch pulse
    output logic                   [31:0] branch_addr,   // Branch target
    output logic                          usage_error,   // Usage error pulse
    output logic                          mem_fault,     // Load fault pulse
    output logic                          done           // Instruction finished
);
    import pli_pop_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_EXEC = 5'b00010,
        ST_POP  = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_DONE = 5'b10000
    } state_type;

    typedef struct packed {
        state_type         st;
        logic [31:0]       instr;
        ctrl_type          ctrl;
        logic [15:0][31:0] regs;
        logic [31:0]       pc;

        logic [15:0]       list;
        logic [3:0]        cur;
        logic [31:0]       addr;
        logic [31:0]       sp_new;
        status_type        stat;

        // Bus answer
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;

        // Port outputs
        mem_req_type       mreq;
        logic              hint_v;
        logic [31:0]       hint_a;
        logic              br_v;
        logic [31:0]       br_a;
        logic              uerr;
        logic              mflt;
        logic              done;
    } unit_type;

    unit_type   r_ff;
    unit_type   nxt_r;
    decode_type dec;
    logic       wr_en;
    logic       setup;
    logic [3:0] reg_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    // Decodes the held instruction word
    pli_pop_decoder u_decoder (
        .hw1           (r_ff.instr[31:16]),
        .hw2           (r_ff.instr[15:0]),
        .is16          (r_ff.ctrl.is16),
        .in_group      (r_ff.ctrl.in_group),
        .last_in_group (r_ff.ctrl.last_in_group),
        .dec           (dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Logical left shift carrying the flag in; carry out returned in bit 32
    function automatic logic [32:0] lsl_c(input logic [31:0] v, input logic [1:0] n,
                                          input logic cin);
        logic [32:0] res;
        res = {cin, v};
        for (int i = 0; i < 3; i++) begin
            if (i < int'(n)) begin
                res = {res[31], res[30:0], 1'b0};
            end
        end
        return res;
    endfunction

    // Lowest listed register; zero when empty
    function automatic logic [3:0] lowest(input logic [15:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // Addresses that answer without error
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == INSTR_OFS) || (a == CTRL_OFS) || (a == STATUS_OFS) ||
               (a == HINT_OFS) || (a == PC_OFS) || (a == BRANCH_OFS) ||
               (a[7:6] == REGS_BANK && a[1:0] == 2'h0);
    endfunction

    // Bus phase and write qualifier
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && r_ff.pready && pwrite && !r_ff.pslverr;
    assign reg_sel = paddr[5:2];

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        // Hint operands
        logic [31:0] base;
        logic [31:0] offs;
        logic [32:0] shifted;
        logic        busy;
        nxt_r   = r_ff;
        base    = 32'h0;
        offs    = 32'h0;
        shifted = 33'h0;
        busy    = (r_ff.st != ST_IDLE);

        // Pulses last one cycle
        nxt_r.hint_v = 1'b0;
        nxt_r.br_v   = 1'b0;
        nxt_r.uerr   = 1'b0;
        nxt_r.mflt   = 1'b0;
        nxt_r.done   = 1'b0;

        // APB: zero wait, answer prepared in the setup cycle
        nxt_r.pready  = setup;
        nxt_r.pslverr = setup && !is_mapped(paddr);
        if (setup) begin
            case (paddr)
                INSTR_OFS:  nxt_r.prdata = r_ff.instr;
                CTRL_OFS:   nxt_r.prdata = {26'h0, r_ff.ctrl & 6'h3E};
                STATUS_OFS: nxt_r.prdata = {24'h0, r_ff.stat};
                HINT_OFS:   nxt_r.prdata = r_ff.hint_a;
                PC_OFS:     nxt_r.prdata = r_ff.pc;
                BRANCH_OFS: nxt_r.prdata = r_ff.br_a;
                default: begin
                    if (paddr[7:6] == REGS_BANK) begin
                        nxt_r.prdata = (reg_sel == PC_IDX) ? r_ff.pc : r_ff.regs[reg_sel];
                    end else begin
                        nxt_r.prdata = 32'h0;
                    end
                end
            endcase
        end

        // Writes are refused while an instruction is in flight
        if (wr_en && !busy) begin
            case (paddr)
                INSTR_OFS: nxt_r.instr = pwdata;
                CTRL_OFS: begin
                    nxt_r.ctrl = ctrl_type'(pwdata[CTRL_IS16_BIT:0]);
                    if (pwdata[CTRL_START_BIT]) begin
                        nxt_r.st        = ST_EXEC;
                        nxt_r.stat      = '0;
                        nxt_r.stat.busy = 1'b1;
                    end
                end
                PC_OFS: nxt_r.pc = pwdata;
                default: begin
                    if (paddr[7:6] == REGS_BANK && reg_sel != PC_IDX) begin
                        nxt_r.regs[reg_sel] = pwdata;
                    end
                end
            endcase
        end
        nxt_r.ctrl.start = 1'b0;

        case (r_ff.st)
            // Waits for a start write
            ST_IDLE: begin
            end

            // Decode result used the cycle after start
            ST_EXEC: begin
                nxt_r.st = ST_DONE;
                nxt_r.stat.unpredictable = dec.unpredictable;
                nxt_r.stat.unaligned_ok  = dec.unaligned_ok;
                if (r_ff.ctrl.cond_pass && !dec.unpredictable) begin
                    if (dec.op == OP_HINT) begin
                        // Address only; no register or flag changes
                        base = (dec.base == PC_IDX) ? (r_ff.pc & ALIGN4)
                                                    : r_ff.regs[dec.base];
                        shifted = lsl_c(r_ff.regs[dec.index], dec.shift,
                                        r_ff.ctrl.carry);
                        offs = dec.use_index ? shifted[31:0] : dec.imm;
                        nxt_r.hint_a = dec.add ? (base + offs) : (base - offs);
                        nxt_r.hint_v = 1'b1;
                        nxt_r.stat.hinted = 1'b1;
                    end else if (dec.op == OP_POP) begin
                        // Stack pointer result is known up front
                        nxt_r.list   = dec.list;
                        nxt_r.addr   = r_ff.regs[SP_IDX];
                        nxt_r.sp_new = r_ff.regs[SP_IDX]
                            + (WORD_BYTES * {27'h0, count_bits(dec.list)});
                        nxt_r.st     = ST_POP;
                    end
                end
            end

            // Load the lowest register still listed
            ST_POP: begin
                if (r_ff.list == 16'h0) begin
                    // List empty: commit the stack pointer
                    nxt_r.regs[SP_IDX] = r_ff.sp_new;
                    nxt_r.st           = ST_DONE;
                end else begin
                    nxt_r.cur               = lowest(r_ff.list);
                    nxt_r.mreq.valid        = 1'b1;
                    nxt_r.mreq.addr         = r_ff.addr;
                    nxt_r.mreq.unaligned_ok = r_ff.stat.unaligned_ok;
                    nxt_r.st                = ST_WAIT;
                end
            end

            // Hold the load until the port answers
            ST_WAIT: begin
                if (mem_ack) begin
                    nxt_r.mreq.valid = 1'b0;
                    // A fault aborts; loaded registers keep values
                    if (mem_err) begin
                        nxt_r.mflt           = 1'b1;
                        nxt_r.stat.mem_fault = 1'b1;
                        nxt_r.st             = ST_DONE;
                    end else if (r_ff.cur == PC_IDX) begin
                        // Counter word comes last: branch or usage error
                        nxt_r.regs[SP_IDX] = r_ff.sp_new;
                        nxt_r.st           = ST_DONE;
                        if (!mem_rdata[0]) begin
                            nxt_r.uerr             = 1'b1;
                            nxt_r.stat.usage_error = 1'b1;
                        end else begin
                            nxt_r.br_a          = mem_rdata & CLR_BIT0;
                            nxt_r.br_v          = 1'b1;
                            nxt_r.pc            = mem_rdata & CLR_BIT0;
                            nxt_r.stat.branched = 1'b1;
                        end
                    end else begin
                        // Ordinary register, then the next word
                        nxt_r.regs[r_ff.cur]     = mem_rdata;
                        nxt_r.list[r_ff.cur]     = 1'b0;
                        nxt_r.addr               = r_ff.addr + WORD_BYTES;
                        nxt_r.st                 = ST_POP;
                    end
                end
            end

            // One-cycle done pulse
            ST_DONE: begin
                nxt_r.done      = 1'b1;
                nxt_r.stat.done = 1'b1;
                nxt_r.stat.busy = 1'b0;
                nxt_r.st        = ST_IDLE;
            end

            default: begin
                nxt_r.st = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff    <= '0;
            r_ff.st <= ST_IDLE;
        end else begin
            r_ff <= nxt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata       = r_ff.prdata;
    assign pready       = r_ff.pready;
    assign pslverr      = r_ff.pslverr;

    assign mem_req      = r_ff.mreq;
    assign hint_valid   = r_ff.hint_v;
    assign hint_addr    = r_ff.hint_a;
    assign branch_valid = r_ff.br_v;
    assign branch_addr  = r_ff.br_a;
    assign usage_error  = r_ff.uerr;
    assign mem_fault    = r_ff.mflt;
    assign done         = r_ff.done;

endmodule
`default_nettype wire

// File: dv/pli_pop_mem.sv
// Purpose: Load port partner returning words derived from the address
// Assumes: One word per request, answered after lat waiting cycles
// Notes:   Read data toggles while idle so stale values never match
`default_nettype none
module pli_pop_mem (
    input  wire logic                     pclk,      // Core clock
    input  wire logic                     presetn,   // Reset, active low
    input  wire pli_pop_pkg::mem_req_type mem_req,   // Load request
    input  wire logic               [3:0] lat,       // Waiting cycles
    input  wire logic                     odd,       // Bit 0 of words
    input  wire logic                     err,       // Answer with error
    output logic                          mem_ack,   // Answer strobe
    output logic                   [31:0] mem_rdata, // Answer data
    output logic                          mem_err,   // Answer error
    output logic                          saw_ua     // Last unaligned flag
);
    timeunit 1ns;
    timeprecision 1ps;
    import pli_pop_pkg::*;
    logic [3:0] cnt_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack   <= 1'b0;
            mem_err   <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            saw_ua    <= 1'b0;
            cnt_ff    <= 4'h0;
        end else if (mem_req.valid && !mem_ack && cnt_ff >= lat) begin
            mem_ack   <= 1'b1;
            mem_err   <= err;
            mem_rdata <= mem_req.addr + 32'h1000_0000 + {31'h0, odd};
            saw_ua    <= mem_req.unaligned_ok;
            cnt_ff    <= 4'h0;
        end else begin
            mem_ack   <= 1'b0;
            mem_err   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt_ff    <= (mem_req.valid && !mem_ack) ? cnt_ff + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// File: dv/pli_pop_monitor.sv
// Purpose: Port checks of the preload-hint and unstack unit
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound from the bench top file
`default_nettype none
module pli_pop_monitor (
    input wire logic                     pclk,         // Clock
    input wire logic                     presetn,      // Reset
    input wire pli_pop_pkg::mem_req_type mem_req,      // Load request
    input wire logic                     mem_ack,      // Load answer
    input wire logic              [31:0] mem_rdata,    // Load data
    input wire logic                     mem_err,      // Load failed
    input wire logic                     hint_valid,   // Hint pulse
    input wire logic                     branch_valid, // Branch pulse
    input wire logic              [31:0] branch_addr,  // Branch target
    input wire logic                     usage_error,  // Usage pulse
    input wire logic                     mem_fault,    // Fault pulse
    input wire logic                     done          // Done pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    import pli_pop_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_hint_then_done: assert property (hint_valid |=> done && !hint_valid)
        else $error("hint not done");
    a_hint_no_load: assert property (hint_valid |-> !mem_req.valid && !branch_valid)
        else $error("hint loads");
    a_usage_cause: assert property (usage_error |-> $past(mem_ack && !mem_rdata[0]))
        else $error("usage cause");
    a_branch_target: assert property (branch_valid |-> branch_addr == ($past(mem_rdata) & CLR_BIT0))
        else $error("branch target");
    a_branch_cause: assert property (branch_valid |-> $past(mem_ack && mem_rdata[0]) ##1 done)
        else $error("branch cause");
    a_fault_cause: assert property (mem_fault |-> $past(mem_ack && mem_err) ##1 done)
        else $error("fault cause");
    a_req_hold: assert property (mem_req.valid && !mem_ack |=> mem_req.valid && $stable(mem_req.addr))
        else $error("request dropped");
    a_next_word: assert property (mem_req.valid && mem_ack && !mem_err ##2 mem_req.valid
        |-> mem_req.addr == $past(mem_req.addr, 2) + WORD_BYTES)
        else $error("next word address");
    cover property (hint_valid);
    cover property (branch_valid);
    cover property (mem_fault);
endmodule
`default_nettype wire

// File: dv/preload_hint_and_unstack_decoder_test.sv
// Purpose: Self-checking bench of the preload-hint and unstack unit
// Assumes: Register bus answers without wait, partner load port model
// Notes:   Table of hint and refused cases, then hand-written unstacks
`default_nettype none
module preload_hint_and_unstack_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pli_pop_pkg::*;

    typedef struct packed {
        logic [31:0] ins;
        logic [7:0]  ctrl;
        logic [7:0]  st;
        logic [15:0] addr;
    } row_type;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        mem_ack, mem_err, hint_valid, branch_valid, usage_error, mem_fault;
    logic        done, odd, err, saw_ua;
    logic [3:0]  lat;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, mem_rdata, hint_addr, branch_addr, rd;
    mem_req_type mem_req;
    int          n_fail, samples_checked;
    row_type     rows [16] = '{
        '{32'hF991_FFFF, 8'h02, 8'h06, 16'h10FF},
        '{32'hF912_FCFF, 8'h02, 8'h06, 16'h0101},
        '{32'hF99F_F123, 8'h02, 8'h06, 16'h3123},
        '{32'hF91F_F010, 8'h02, 8'h06, 16'h2FF0},
        '{32'hF993_F000, 8'h02, 8'h06, 16'h0300},
        '{32'hF914_FC00, 8'h02, 8'h06, 16'h0400},
        '{32'hF914_F035, 8'h12, 8'h06, 16'h2C00},
        '{32'hF916_F001, 8'h02, 8'h06, 16'h0700},
        '{32'hF91F_F025, 8'h02, 8'h06, 16'h2FDB},
        '{32'hF99D_F004, 8'h02, 8'h06, 16'h2004},
        '{32'hF991_F001, 8'h00, 8'h02, 16'h0000},
        '{32'hF914_F00D, 8'h02, 8'h42, 16'h0000},
        '{32'hE8BD_C001, 8'h02, 8'h42, 16'h0000},
        '{32'hF85D_DB04, 8'h02, 8'h42, 16'h0000},
        '{32'hBC00_0000, 8'h22, 8'h42, 16'h0000},
        '{32'hBD01_0000, 8'h26, 8'h42, 16'h0000}
    };

    pli_pop_unit u_pli_pop_unit (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .mem_req, .mem_ack, .mem_rdata, .mem_err, .hint_valid,
        .hint_addr, .branch_valid, .branch_addr, .usage_error, .mem_fault, .done);
    pli_pop_mem u_pli_pop_mem (.pclk, .presetn, .mem_req, .lat, .odd, .err, .mem_ack,
        .mem_rdata, .mem_err, .saw_ua);

    always #5 pclk = ~pclk;

    task automatic print_verdict();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            print_verdict();
        end
        @(posedge pclk);
    endtask

    // Loads and starts one instruction, then polls until done
    task automatic run(input logic [31:0] ins, input logic [7:0] ctrl);
        int n;
        apb(1'b1, INSTR_OFS, ins);
        apb(1'b1, CTRL_OFS, {24'h0, ctrl | 8'h01});
        n = 0;
        do begin
            apb(1'b0, STATUS_OFS, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_fail++;
            print_verdict();
        end
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lat = 4'h0;
        odd = 1'b1;
        err = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        check({31'h0, er}, 32'h1);
        for (int i = 0; i < 13; i++) begin
            apb(1'b1, 8'h40 + 8'(4 * i), 32'(i << 8));
        end
        apb(1'b1, 8'h74, 32'h0000_2000);
        apb(1'b1, PC_OFS, 32'h0000_3002);
        foreach (rows[i]) begin
            run(rows[i].ins, rows[i].ctrl);
            check({25'h0, rd[6:0]}, {24'h0, rows[i].st});
            if (rows[i].st[2]) begin
                apb(1'b0, HINT_OFS, 32'h0);
                check(rd, {16'h0, rows[i].addr});
                check(hint_addr, {16'h0, rows[i].addr});
            end
        end
        apb(1'b0, 8'h44, 32'h0);
        check(rd, 32'h0000_0100);
        lat <= 4'h3;
        run(32'hBD81_0000, 8'h22);
        check({25'h0, rd[6:0]}, 32'h0A);
        check({31'h0, saw_ua}, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h1000_2001);
        apb(1'b0, 8'h5C, 32'h0);
        check(rd, 32'h1000_2005);
        apb(1'b0, BRANCH_OFS, 32'h0);
        check(rd, 32'h1000_2008);
        apb(1'b0, 8'h74, 32'h0);
        check(rd, 32'h0000_200C);
        odd <= 1'b0;
        lat <= 4'h0;
        run(32'hF85D_FB04, 8'h02);
        check({25'h0, rd[6:0]}, 32'h12);
        check({31'h0, saw_ua}, 32'h1);
        apb(1'b0, 8'h74, 32'h0);
        check(rd, 32'h0000_2010);
        err <= 1'b1;
        lat <= 4'h2;
        run(32'hE8BD_0006, 8'h02);
        check({25'h0, rd[6:0]}, 32'h22);
        apb(1'b0, 8'h74, 32'h0);
        check(rd, 32'h0000_2010);
        err <= 1'b0;
        odd <= 1'b1;
        run(32'hBD01_0000, 8'h2E);
        check({25'h0, rd[6:0]}, 32'h0A);
        check(branch_addr, 32'h1000_2014);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h74, 32'h0);
        check(rd, 32'h0);
        print_verdict();
    end
endmodule

bind pli_pop_unit pli_pop_monitor u_pli_pop_monitor (.pclk, .presetn, .mem_req, .mem_ack,
    .mem_rdata, .mem_err, .hint_valid, .branch_valid, .branch_addr, .usage_error,
    .mem_fault, .done);
`default_nettype wire
